/* include/ivtw_map.vh */
/*
 * register indices, field positions, reset values and counts of the
 * interval timer and supervision block.
 * assumes: included by the design and bench files of this block only.
 */
`ifndef IVTW_MAP_VH
`define IVTW_MAP_VH

// register indices; byte address is four times the index
`define IVTW_IDX_SUP_CLEAR 10'h0cc
`define IVTW_IDX_MODE 10'h0d8
`define IVTW_IDX_COUNT 10'h0d9
`define IVTW_IDX_IRQ_STATUS 10'h0f0
`define IVTW_IDX_IRQ_CLEAR 10'h0f1
`define IVTW_IDX_IRQ_ENABLE 10'h0f2

// mode register fields
`define IVTW_MODE_RUN_BIT 7
`define IVTW_MODE_RATE_MSB 6
`define IVTW_MODE_RATE_LSB 4

// interrupt status bits
`define IVTW_IRQ_TIMER_BIT 0
`define IVTW_IRQ_WAKE_BIT 1
`define IVTW_IRQ_BITS 2

// reset values
`define IVTW_MODE_RESET 8'h00
`define IVTW_COUNT_RESET 8'h00
`define IVTW_SUP_CLEAR_RESET 8'h00

// supervision clear key and overflow length in oscillator periods
`define IVTW_SUP_CLEAR_KEY 8'h5a
`define IVTW_SUP_PERIODS 8192
`define IVTW_SUP_WIDTH 13

// bus answers
`define IVTW_RESP_OKAY 2'b00
`define IVTW_RESP_SLVERR 2'b10

`endif

/* src/ivtw_supervisor.v */
/*
 * supervision counter: counts periods of the low-speed oscillator and
 * asks for a chip reset on overflow unless cleared in time.
 * assumes: osc_low is an asynchronous pin; option inputs are fixed
 * straps; clear_pulse is one clk_sys cycle long.
 */
`include "ivtw_map.vh"

module ivtw_supervisor
#(
    parameter PERIODS = `IVTW_SUP_PERIODS,
    parameter WIDTH = `IVTW_SUP_WIDTH
)
(
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // oscillator and options
    input wire osc_low,
    input wire sup_enable,
    input wire sup_always_on,
    input wire chip_sleep,
    // control and result
    input wire clear_pulse,
    output reg chip_reset_req_reg,
    output reg [WIDTH-1:0] count_reg
);

    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg osc_level_reg;
    wire osc_rise;
    wire counting;

    ////////////////////////////////////////////////////////////////////
    // three-stage synchroniser; the level is accepted only once the
    // second and third stage agree, so a single glitch never counts
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            osc_level_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= osc_low;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg)
                osc_level_reg <= sync3_reg;
        end
    end

    // one oscillator period per accepted rising edge
    assign osc_rise = (sync2_reg == sync3_reg) && sync3_reg && !osc_level_reg;

    // paused in sleep unless the always-running option is strapped
    assign counting = sup_enable && (sup_always_on || !chip_sleep);

    ////////////////////////////////////////////////////////////////////
    // binary up counter; overflow after the last of PERIODS ticks
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            count_reg <= {WIDTH{1'b0}};
            chip_reset_req_reg <= 1'b0;
        end
        else
        begin
            chip_reset_req_reg <= 1'b0;
            if (clear_pulse || !sup_enable)
                count_reg <= {WIDTH{1'b0}};
            else if (counting && osc_rise)
            begin
                if (count_reg == PERIODS[WIDTH-1:0] - 1'b1)
                begin
                    count_reg <= {WIDTH{1'b0}};
                    chip_reset_req_reg <= 1'b1;
                end
                else
                    count_reg <= count_reg + 1'b1;
            end
        end
    end

endmodule // ivtw_supervisor

/* src/ivtw_top.v */
/*
 * interval timer and supervision unit behind an AXI4-Lite slave:
 * 8-bit prescaled up timer with request flag and green-mode wake, and
 * a supervision counter fed by the low-speed oscillator.
 * assumes: one clock clk_sys; osc_low is an asynchronous pin; the
 * option straps are stable; chip_reset_req is acted on by chip reset.
 */
// The AXI4-Lite slave port was chosen for this implementation.
// Behaviour
// - the supervision counter counts up and its overflow resets the whole chip.
// - it overflows after 8192 oscillator periods since its last clear or reset.
// - it runs only from the low-speed oscillator, enabled by a strap, not a register.
// - with the always-running strap it keeps counting in power-down and green mode.
// - writing 0x5a to the write-only clear register restarts it at zero.
// - the timer is an 8-bit up counter that keeps counting past ff and pulses on wrap.
// - with the run bit set, a timer wrap wakes the chip from green mode.
// - rate field bits 6:4 pick the count clock, divide by 256 at 000 down to 2 at 111.
// - mode bit 7 starts and stops the timer; all mode bits reset to zero.
// - the count register is readable and writable at any time and resets to zero.
// - every wrap sets the request flag; the interrupt fires only when enabled.
`include "ivtw_map.vh"

module ivtw_top
(
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // oscillator, straps and power state
    input wire osc_low,
    input wire sup_enable,
    input wire sup_always_on,
    input wire chip_sleep,
    // chip-level outputs
    output wire chip_reset_req,
    output reg green_wake,
    output reg irq
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // prescaler mask: divisor is 256 >> rate, tick when low bits all set
    function [7:0] rate_mask;
        input [2:0] rate;
        begin
            rate_mask = 8'hff >> rate;
        end
    endfunction

    // true when a word address hits a register index
    function hit;
        input [11:0] addr;
        input [9:0] index;
        begin
            hit = (addr[11:2] == index);
        end
    endfunction

    // true for every index that is mapped
    function mapped;
        input [11:0] addr;
        begin
            mapped = hit(addr, `IVTW_IDX_SUP_CLEAR) || hit(addr, `IVTW_IDX_MODE) ||
                hit(addr, `IVTW_IDX_COUNT) || hit(addr, `IVTW_IDX_IRQ_STATUS) ||
                hit(addr, `IVTW_IDX_IRQ_CLEAR) || hit(addr, `IVTW_IDX_IRQ_ENABLE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    reg [11:0] waddr_reg;
    reg [7:0] wbyte_reg;
    reg wlane_reg;
    reg aw_held_reg;
    reg w_held_reg;
    wire do_write;
    wire wr_lane;

    reg [7:0] mode_reg;
    reg [7:0] count_reg;
    reg [7:0] pre_reg;
    reg [`IVTW_IRQ_BITS-1:0] status_reg;
    reg [`IVTW_IRQ_BITS-1:0] enable_reg;
    reg [`IVTW_IRQ_BITS-1:0] status_next;
    reg [`IVTW_IRQ_BITS-1:0] set_mask;
    reg [`IVTW_IRQ_BITS-1:0] clr_mask;
    reg sup_clear_reg;

    wire run;
    wire [2:0] rate;
    wire tick;
    wire count_write;
    wire wrap;
    wire [`IVTW_SUP_WIDTH-1:0] sup_count;
    reg [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data are taken in either order and
    // held; the write happens once both are in and no answer is pending
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= 12'h000;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IVTW_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                waddr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
                w_held_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr_reg) ? `IVTW_RESP_OKAY : `IVTW_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    // registers are eight bits wide, so only byte lane 0 stores
    assign wr_lane = do_write && wlane_reg;

    ////////////////////////////////////////////////////////////////////
    // mode register: run bit and rate field
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            mode_reg <= `IVTW_MODE_RESET;
        else if (wr_lane && hit(waddr_reg, `IVTW_IDX_MODE))
            mode_reg <= {wbyte_reg[7:4], 4'h0};
    end

    assign run = mode_reg[`IVTW_MODE_RUN_BIT];
    assign rate = mode_reg[`IVTW_MODE_RATE_MSB:`IVTW_MODE_RATE_LSB];

    ////////////////////////////////////////////////////////////////////
    // prescaler: free count of clk_sys cycles while running, cleared on
    // stop so that the first interval after a start is a full one
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            pre_reg <= 8'h00;
        else if (run)
            pre_reg <= pre_reg + 8'h01;
        else
            pre_reg <= 8'h00;
    end

    assign tick = run && ((pre_reg & rate_mask(rate)) == rate_mask(rate));

    ////////////////////////////////////////////////////////////////////
    // timer count: a software write takes priority over the increment,
    // so a load in the same cycle as a wrap suppresses that wrap
    assign count_write = wr_lane && hit(waddr_reg, `IVTW_IDX_COUNT);
    assign wrap = tick && (count_reg == 8'hff) && !count_write;

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            count_reg <= `IVTW_COUNT_RESET;
        else if (count_write)
            count_reg <= wbyte_reg;
        else if (tick)
            count_reg <= count_reg + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////
    // green-mode wake pulse, one cycle after the wrap
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            green_wake <= 1'b0;
        else
            green_wake <= wrap && run;
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, write-one-to-clear, a set in the same
    // cycle as its clear wins so no wrap is ever lost
    always @*
    begin
        set_mask = {`IVTW_IRQ_BITS{1'b0}};
        set_mask[`IVTW_IRQ_TIMER_BIT] = wrap;
        set_mask[`IVTW_IRQ_WAKE_BIT] = wrap && run && chip_sleep;
        clr_mask = {`IVTW_IRQ_BITS{1'b0}};
        if (wr_lane && hit(waddr_reg, `IVTW_IDX_IRQ_CLEAR))
            clr_mask = wbyte_reg[`IVTW_IRQ_BITS-1:0];
        status_next = (status_reg & ~clr_mask) | set_mask;
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg <= {`IVTW_IRQ_BITS{1'b0}};
            enable_reg <= {`IVTW_IRQ_BITS{1'b0}};
        end
        else
        begin
            status_reg <= status_next;
            if (wr_lane && hit(waddr_reg, `IVTW_IDX_IRQ_ENABLE))
                enable_reg <= wbyte_reg[`IVTW_IRQ_BITS-1:0];
        end
    end

    // level output, follows the status one cycle later
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & enable_reg);
    end

    ////////////////////////////////////////////////////////////////////
    // supervision clear: only the exact key restarts the counter; any
    // other value is accepted on the bus and ignored
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            sup_clear_reg <= 1'b0;
        else
            sup_clear_reg <= wr_lane && hit(waddr_reg, `IVTW_IDX_SUP_CLEAR) &&
                (wbyte_reg == `IVTW_SUP_CLEAR_KEY);
    end

    ivtw_supervisor
    #(
        .PERIODS(`IVTW_SUP_PERIODS),
        .WIDTH(`IVTW_SUP_WIDTH)
    )
    u_supervisor
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .osc_low(osc_low),
        .sup_enable(sup_enable),
        .sup_always_on(sup_always_on),
        .chip_sleep(chip_sleep),
        .clear_pulse(sup_clear_reg),
        .chip_reset_req_reg(chip_reset_req),
        .count_reg(sup_count)
    );

    ////////////////////////////////////////////////////////////////////
    // read decode; write-only registers and reserved bits read as zero
    always @*
    begin
        rd_word = 32'h00000000;
        if (hit(s_axi_araddr, `IVTW_IDX_MODE))
            rd_word[7:0] = mode_reg;
        else if (hit(s_axi_araddr, `IVTW_IDX_COUNT))
            rd_word[7:0] = count_reg;
        else if (hit(s_axi_araddr, `IVTW_IDX_IRQ_STATUS))
            rd_word[`IVTW_IRQ_BITS-1:0] = status_reg;
        else if (hit(s_axi_araddr, `IVTW_IDX_IRQ_ENABLE))
            rd_word[`IVTW_IRQ_BITS-1:0] = enable_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one outstanding read, data one cycle after address
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IVTW_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(s_axi_araddr) ? `IVTW_RESP_OKAY : `IVTW_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // ivtw_top

/* bench/ivtw_monitor.sv */
/* checker for the bus handshakes and event outputs of the timer unit.
   assumes: bound to ivtw_top; the master asks for one transfer at a time. */
`include "ivtw_map.vh"

module ivtw_monitor
(
    // clock and reset
    input logic clk_sys,
    input logic resetn,
    // write channels
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    // read channels
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    // chip-level outputs
    input logic chip_reset_req,
    input logic green_wake,
    input logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////
    // bus answers
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `IVTW_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");

    ////////////////////////////////////////////////////////////////////
    // event outputs are single pulses; irq drops only after a write
    AST_RESET_PULSE: assert property (chip_reset_req |=> !chip_reset_req)
        else $error("reset request too long");
    AST_WAKE_PULSE: assert property (green_wake |=> !green_wake)
        else $error("wake pulse too long");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("irq dropped without software");

    COV_RESET: cover property (chip_reset_req);
    COV_WAKE: cover property (green_wake);
    COV_IRQ: cover property ($rose(irq));
endmodule // ivtw_monitor

/* bench/ivtw_bench.sv */
/* self-checking bench of the interval timer and supervision unit.
   assumes: the oscillator runs at eight clk_sys periods to keep the run short. */
`include "ivtw_map.vh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module ivtw_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_SUP = {`IVTW_IDX_SUP_CLEAR, 2'b00};
    localparam logic [11:0] A_MODE = {`IVTW_IDX_MODE, 2'b00};
    localparam logic [11:0] A_CNT = {`IVTW_IDX_COUNT, 2'b00};
    localparam logic [11:0] A_STAT = {`IVTW_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_CLR = {`IVTW_IDX_IRQ_CLEAR, 2'b00};
    localparam logic [11:0] A_EN = {`IVTW_IDX_IRQ_ENABLE, 2'b00};
    logic clk_sys = 1'b0, resetn = 1'b0, osc_low = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, rd_data;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic sup_enable = 1'b0, sup_always_on = 1'b0, chip_sleep = 1'b0;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire chip_reset_req, green_wake, irq;
    int mismatches = 0, check_count = 0, n, t, cyc_n = 0;

    ////////////////////////////////////////////////////////////////////
    // clocks; the oscillator edges fall on clk_sys falling edges, between rising edges
    always #20 clk_sys = ~clk_sys;
    always #160 osc_low = ~osc_low;
    // cycle stamp for measuring long spans
    always @(posedge clk_sys) cyc_n <= cyc_n + 1;

    ivtw_top uut (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_low, .sup_enable,
        .sup_always_on, .chip_sleep, .chip_reset_req, .green_wake, .irq);

    ////////////////////////////////////////////////////////////////////
    // bus tasks: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bit done = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50 && !done; k++)
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                resp = s_axi_bresp;
                done = 1'b1;
            end
        end
        // a write that never answers is a mismatch, not a silent hang
        `CHECK("write answer", 1'b1, done)
    endtask

    task automatic rd(input logic [11:0] a);
        bit done = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50 && !done; k++)
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                rd_data = s_axi_rdata;
                resp = s_axi_rresp;
                done = 1'b1;
            end
        end
        `CHECK("read answer", 1'b1, done)
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        rd(a);
        `CHECK($sformatf("reg %h", a), {24'h0, e}, rd_data)
    endtask

    // stop, mask, clear, set rate, load; caller unmasks and starts
    task automatic arm(input int r, input logic [7:0] c);
        wr(A_MODE, 8'h00);
        wr(A_EN, 8'h00);
        wr(A_CLR, 8'h03);
        wr(A_MODE, {1'b0, 3'(r), 4'h0});
        wr(A_CNT, c);
    endtask

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        rchk(A_MODE, 8'h00);
        rchk(A_CNT, 8'h00);
        rchk(A_SUP, 8'h00);
        rd(12'h000);
        `CHECK("unmapped read", `IVTW_RESP_SLVERR, resp)
        wr(12'h004, 8'h11);
        `CHECK("unmapped write", `IVTW_RESP_SLVERR, resp)
        wr(A_MODE, 8'hff);
        rchk(A_MODE, 8'hf0);
        // flag sets while masked, irq follows the enable
        arm(7, 8'hfd);
        wr(A_MODE, 8'hf0);
        repeat (20) @(posedge clk_sys);
        rchk(A_STAT, 8'h01);
        `CHECK("masked irq", 1'b0, irq)
        wr(A_EN, 8'h01);
        repeat (2) @(posedge clk_sys);
        `CHECK("irq", 1'b1, irq)
        wr(A_CLR, 8'h01);
        repeat (2) @(posedge clk_sys);
        `CHECK("cleared irq", 1'b0, irq)
        // a stopped timer takes a load and then holds it
        wr(A_MODE, 8'h70);
        wr(A_CNT, 8'h5c);
        rchk(A_CNT, 8'h5c);
        repeat (10) @(posedge clk_sys);
        rchk(A_CNT, 8'h5c);
        // every rate: wrap from ff after 256 >> rate cycles
        for (int r = 0; r < 8; r++)
        begin
            arm(r, 8'hff);
            wr(A_EN, 8'h01);
            wr(A_MODE, {1'b1, 3'(r), 4'h0});
            n = 0;
            while (!irq && n < 400)
            begin
                @(posedge clk_sys);
                n++;
            end
            `CHECK("rate", 1'b1, n >= (256 >> r) - 2 && n <= (256 >> r) + 3)
        end
        // preload for five ticks at divide by 16; irq seen one edge later
        arm(4, 8'd251);
        wr(A_EN, 8'h01);
        wr(A_MODE, 8'hc0);
        n = 0;
        while (!irq && n < 400)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHECK("preload interval", 81, n)
        // wrap while asleep wakes the chip
        arm(7, 8'hff);
        chip_sleep <= 1'b1;
        wr(A_MODE, 8'hf0);
        n = 0;
        while (!green_wake && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHECK("wake", 1'b1, green_wake)
        rchk(A_STAT, 8'h03);
        wr(A_MODE, 8'h00);
        // supervision pauses asleep without the always-on strap, counts
        // asleep with it, and a wrong key does not clear it
        sup_enable <= 1'b1;
        wr(A_SUP, `IVTW_SUP_CLEAR_KEY);
        t = cyc_n;
        repeat (2000) @(posedge clk_sys);
        sup_always_on <= 1'b1;
        repeat (2000) @(posedge clk_sys);
        wr(A_SUP, 8'h5b);
        while (!chip_reset_req && cyc_n - t < 72000)
            @(posedge clk_sys);
        n = cyc_n - t - `IVTW_SUP_PERIODS * 8 - 2000;
        `CHECK("overflow time", 1'b1, n >= -20 && n <= 20)
        print_verdict();
    end

    // hang guard, well past the expected run length
    initial
    begin
        #3200000;
        mismatches++;
        print_verdict();
    end
endmodule // ivtw_bench

bind ivtw_top ivtw_monitor mon (.clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .chip_reset_req,
    .green_wake, .irq);
